// ===== logic/sdd_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - External reset clears the detection control register to zero.
// - Control register accepts single-bit writes and whole-byte writes.
// - Low-voltage flag at bit 0 is read-only; writes never change it.
// - Enables and mode clear on every reset except a detector reset.
// - Mode 0 requests interrupt; mode 1 asserts internal reset when low.
// - Flag reads 1 when supply below threshold, 0 otherwise or disabled.
// - With enable 1 and mode 0, the flag drives the interrupt request.
// - With power-on-clear fitted, reference enable has no effect.
// - Level register bits 2..0 pick one of seven levels; code 7 prohibited.
// - A detector reset sets bit 0 of the reset-cause register.
// - Power-on-clear overriding levels 4 to 6 takes priority over detector.
// - Detector keeps working in stop mode.
// - Interrupt may be raised as soon as detector enable is set.
// - Choosing reset mode while supply is fine causes no reset.
// - Power-on-clear asserts internal reset while supply below its level.
// - A power-on-clear reset clears the whole reset-cause register.
module sdd_ctrl
  import sdd_pkg::*;
#(
  parameter bit POC_FITTED = 1'b1
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        other_reset,
  input  wire logic        poc_below,
  input  wire logic        cmp_below,
  input  wire logic        stop_mode,
  input  wire logic        bus_wr,
  input  wire logic        bus_bit_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_addr,
  input  wire logic [2:0]  bus_bit_sel,
  input  wire logic        bus_bit_val,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  output logic      [2:0]  level_sel,
  output logic             cmp_enable,
  output logic             ref_enable,
  output logic             droop_interrupt_request,
  output logic             internal_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic       detector_enable_ff;
  logic       reference_enable_ff;
  logic       reset_mode_select_ff;
  logic       low_voltage_flag_ff;
  logic [2:0] level_ff;
  logic [7:0] reset_cause_register_ff;
  logic       cmp_sync;
  logic       poc_sync;
  logic       wr_ctrl;
  logic       wr_level;
  logic       droop_reset_hit;
  logic       any_int_reset;
  logic       nxt_det_en;
  logic       nxt_ref_en;
  logic       nxt_mode;

  // Bus write kind decoded once
  function automatic sdd_wr_t wr_kind(input logic wr, input logic bit_wr);
    if (bit_wr) begin
      wr_kind = SDD_WR_BIT;
    end else if (wr) begin
      wr_kind = SDD_WR_BYTE;
    end else begin
      wr_kind = SDD_WR_NONE;
    end
  endfunction

  // Merge one byte-or-bit write into a single control bit
  function automatic logic merge_bit(input logic cur, input int pos, input sdd_wr_t k,
                                     input logic [2:0] sel, input logic val,
                                     input logic [7:0] data);
    case (k)
      SDD_WR_BYTE: merge_bit = data[pos];
      SDD_WR_BIT:  merge_bit = (int'(sel) == pos) ? val : cur;
      default:     merge_bit = cur;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Comparator and power-on-clear inputs are asynchronous
  sdd_sync u_cmp_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (cmp_below),
    .sync_out (cmp_sync)
  );

  sdd_sync u_poc_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (poc_below),
    .sync_out (poc_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_ctrl  = (bus_wr | bus_bit_wr) & (bus_addr == SDD_ADDR_CTRL);
  // Level register takes byte writes only; bit writes there are ignored
  assign wr_level = bus_wr & ~bus_bit_wr & (bus_addr == SDD_ADDR_LEVEL);

  // Detector reset only in reset mode with a real low reading
  assign droop_reset_hit = detector_enable_ff & reset_mode_select_ff & cmp_sync;
  // Power-on-clear and other sources are non-detector resets
  assign any_int_reset   = poc_sync | other_reset;

  // Next values of the writable control bits
  always_comb begin
    nxt_det_en = detector_enable_ff;
    nxt_ref_en = reference_enable_ff;
    nxt_mode   = reset_mode_select_ff;
    if (wr_ctrl) begin
      nxt_det_en = merge_bit(detector_enable_ff, SDD_BIT_DET_EN,
                             wr_kind(bus_wr, bus_bit_wr), bus_bit_sel,
                             bus_bit_val, bus_wdata);
      nxt_ref_en = merge_bit(reference_enable_ff, SDD_BIT_REF_EN,
                             wr_kind(bus_wr, bus_bit_wr), bus_bit_sel,
                             bus_bit_val, bus_wdata);
      nxt_mode   = merge_bit(reset_mode_select_ff, SDD_BIT_MODE,
                             wr_kind(bus_wr, bus_bit_wr), bus_bit_sel,
                             bus_bit_val, bus_wdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits; a detector reset leaves them untouched
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      detector_enable_ff   <= SDD_CTRL_RST[SDD_BIT_DET_EN];
      reference_enable_ff  <= SDD_CTRL_RST[SDD_BIT_REF_EN];
      reset_mode_select_ff <= SDD_CTRL_RST[SDD_BIT_MODE];
    end else if (any_int_reset) begin
      detector_enable_ff   <= 1'b0;
      reference_enable_ff  <= 1'b0;
      reset_mode_select_ff <= 1'b0;
    end else if (!droop_reset_hit) begin
      detector_enable_ff   <= nxt_det_en;
      reference_enable_ff  <= nxt_ref_en;
      reset_mode_select_ff <= nxt_mode;
    end
  end

  // Flag follows comparator only while enabled; stop mode does not gate it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_voltage_flag_ff <= SDD_CTRL_RST[SDD_BIT_FLAG];
    end else begin
      low_voltage_flag_ff <= detector_enable_ff & cmp_sync;
    end
  end

  // Level select, held through detector resets too
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      level_ff <= SDD_LEVEL_RST;
    end else if (any_int_reset) begin
      level_ff <= SDD_LEVEL_RST;
    end else if (wr_level) begin
      level_ff <= bus_wdata[2:0];
    end
  end

  // Reset cause: power-on-clear wipes it, detector reset sets bit 0
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reset_cause_register_ff <= SDD_CAUSE_RST;
    end else if (poc_sync) begin
      reset_cause_register_ff <= SDD_CAUSE_RST;
    end else if (droop_reset_hit) begin
      reset_cause_register_ff[SDD_BIT_RST_CAUSE] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      droop_interrupt_request <= 1'b0;
      internal_reset          <= 1'b0;
      cmp_enable              <= 1'b0;
      ref_enable              <= 1'b0;
      level_sel               <= SDD_LEVEL_RST;
    end else begin
      // Request mirrors the flag path at once, no latch
      droop_interrupt_request <= detector_enable_ff & ~reset_mode_select_ff
                                 & cmp_sync;
      // Power-on-clear wins over the detector when both are low
      internal_reset          <= poc_sync | droop_reset_hit;
      // Follow the frozen bits during a detector reset, or the pins glitch off
      cmp_enable              <= (droop_reset_hit ? detector_enable_ff : nxt_det_en)
                                 & ~any_int_reset;
      // With power-on-clear the reference always runs
      ref_enable              <= POC_FITTED
                                 | ((droop_reset_hit ? reference_enable_ff : nxt_ref_en)
                                    & ~any_int_reset);
      level_sel               <= level_ff;
    end
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        SDD_ADDR_CTRL:  bus_rdata <= {detector_enable_ff, 2'b00, reference_enable_ff,
                                      2'b00, reset_mode_select_ff, low_voltage_flag_ff};
        SDD_ADDR_LEVEL: bus_rdata <= {5'h00, level_ff};
        SDD_ADDR_CAUSE: bus_rdata <= reset_cause_register_ff;
        default:        bus_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ===== logic/sdd_pkg.sv
package sdd_pkg;
  // Register addresses on the processor data bus
  localparam logic [15:0] SDD_ADDR_CTRL  = 16'hffbe;
  localparam logic [15:0] SDD_ADDR_LEVEL = 16'hffbf;
  localparam logic [15:0] SDD_ADDR_CAUSE = 16'hffac;

  // Control register bit positions, plus the reset-cause register bit
  localparam int SDD_BIT_FLAG    = 0;
  localparam int SDD_BIT_MODE    = 1;
  localparam int SDD_BIT_REF_EN  = 4;
  localparam int SDD_BIT_DET_EN  = 7;
  localparam int SDD_BIT_RST_CAUSE = 0;

  // Values after reset
  localparam logic [7:0] SDD_CTRL_RST  = 8'h00;
  localparam logic [2:0] SDD_LEVEL_RST = 3'h0;
  localparam logic [7:0] SDD_CAUSE_RST = 8'h00;

  // Level codes
  localparam logic [2:0] SDD_LEVEL_PROHIB  = 3'h7;
  localparam logic [2:0] SDD_LEVEL_POC_LOW = 3'h4;

  // Software wait figures, in microseconds, and derived cycle counts at 20 MHz
  localparam int SDD_CLK_KHZ       = 20000;
  localparam int SDD_DET_SETTLE_US = 200;
  localparam int SDD_REF_SETTLE_US = 2000;
  localparam int SDD_DET_SETTLE_CYC = SDD_DET_SETTLE_US * SDD_CLK_KHZ / 1000;
  localparam int SDD_REF_SETTLE_CYC = SDD_REF_SETTLE_US * SDD_CLK_KHZ / 1000;

  // Bus cycle kinds
  typedef enum logic [1:0] {
    SDD_WR_NONE = 2'b00,
    SDD_WR_BYTE = 2'b01,
    SDD_WR_BIT  = 2'b11
  } sdd_wr_t;
endpackage

// ===== logic/sdd_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for an asynchronous level
module sdd_sync
  import sdd_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_ff;

  // First stage is read only by the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff  <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

// ===== tb/low_voltage_detect_control_tb.sv
`timescale 1ns/1ps
module low_voltage_detect_control_tb;
  import sdd_pkg::*;
  logic        mclk, rst, other_reset, poc_below, cmp_below, stop_mode;
  logic        bus_wr, bus_bit_wr, bus_rd, bus_bit_val, cmp_enable, ref_enable, irq, irst;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata;
  logic [2:0]  bus_bit_sel, level_sel;
  int          n_fail, comparisons;
  int          i;

  sdd_ctrl DUT (.mclk(mclk), .rst(rst), .other_reset(other_reset), .poc_below(poc_below),
    .cmp_below(cmp_below), .stop_mode(stop_mode), .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_bit_sel(bus_bit_sel), .bus_bit_val(bus_bit_val),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .level_sel(level_sel),
    .cmp_enable(cmp_enable), .ref_enable(ref_enable), .droop_interrupt_request(irq),
    .internal_reset(irst));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", w, exp, got);
    end
  endtask
  // Bit writes reuse d: bit 7 is the value, bits 2..0 the index
  task automatic wr(input logic bitw, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_addr    <= a;
    bus_wdata   <= d;
    bus_bit_sel <= d[2:0];
    bus_bit_val <= d[7];
    bus_wr      <= !bitw;
    bus_bit_wr  <= bitw;
    @(posedge mclk);
    bus_wr     <= 1'b0;
    bus_bit_wr <= 1'b0;
  endtask
  // Sampled a cycle late; read data holds until the next read anyway
  task automatic rdc(input string w, input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    @(posedge mclk);
    #1 chk(w, bus_rdata, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc("ctrl", SDD_ADDR_CTRL, 8'h00);
    rdc("level", SDD_ADDR_LEVEL, 8'h00);
    chk("ref_en", {7'h0, ref_enable}, 8'h01);
  endtask
  task automatic t_mode;
    // Power-on-clear fitted, so no reference settling wait
    wr(1'b0, SDD_ADDR_CTRL, 8'h91);
    rdc("ctrl", SDD_ADDR_CTRL, 8'h90);
    // Supply confirmed fine before the mode bit is set
    wr(1'b1, SDD_ADDR_CTRL, 8'h81);
    wr(1'b1, SDD_ADDR_CTRL, 8'h80);
    rdc("ctrl", SDD_ADDR_CTRL, 8'h92);
    chk("irst", {7'h0, irst}, 8'h00);
  endtask
  task automatic t_det_reset;
    @(posedge mclk);
    cmp_below <= 1'b1;
    cyc(6); // Ideal comparator settles at once
    chk("irst", {7'h0, irst}, 8'h01);
    wr(1'b0, SDD_ADDR_CTRL, 8'h00);
    rdc("cause", SDD_ADDR_CAUSE, 8'h01);
    rdc("ctrl", SDD_ADDR_CTRL, 8'h93);
    @(posedge mclk);
    cmp_below <= 1'b0;
    cyc(6);
    chk("irst", {7'h0, irst}, 8'h00);
    wr(1'b0, SDD_ADDR_CTRL, 8'h00);
    rdc("ctrl", SDD_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_irq;
    for (i = 0; i < 7; i++) begin
      wr(1'b0, SDD_ADDR_LEVEL, 8'(i)); // Byte writes, upper bits zero
      rdc("level", SDD_ADDR_LEVEL, 8'(i));
      chk("level_sel", {5'h0, level_sel}, 8'(i));
    end
    wr(1'b1, SDD_ADDR_LEVEL, 8'h80);
    rdc("level", SDD_ADDR_LEVEL, 8'h06);
    wr(1'b0, SDD_ADDR_CTRL, 8'h90);
    @(posedge mclk);
    stop_mode <= 1'b1;
    cmp_below <= 1'b1;
    cyc(6);
    chk("irq", {7'h0, irq}, 8'h01);
    rdc("ctrl", SDD_ADDR_CTRL, 8'h91);
    wr(1'b1, SDD_ADDR_CTRL, 8'h07); // Detector enable cleared; reference enable stays set
    cyc(3);
    chk("irq", {7'h0, irq}, 8'h00);
    rdc("ctrl", SDD_ADDR_CTRL, 8'h10);
    @(posedge mclk);
    cmp_below <= 1'b0;
    stop_mode <= 1'b0;
  endtask
  // Cause register still holds the detector flag until power-on-clear
  task automatic t_resets;
    wr(1'b0, SDD_ADDR_CTRL, 8'h90);
    @(posedge mclk);
    other_reset <= 1'b1;
    @(posedge mclk);
    other_reset <= 1'b0;
    rdc("ctrl", SDD_ADDR_CTRL, 8'h00);
    wr(1'b0, SDD_ADDR_CTRL, 8'h90);
    @(posedge mclk);
    poc_below <= 1'b1;
    cyc(6);
    chk("irst", {7'h0, irst}, 8'h01);
    @(posedge mclk);
    poc_below <= 1'b0;
    cyc(6);
    rdc("cause", SDD_ADDR_CAUSE, 8'h00);
    rdc("ctrl", SDD_ADDR_CTRL, 8'h00);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Main sequence, rst held high for four cycles and all other inputs quiet from time zero
  initial begin
    {rst, other_reset, poc_below, cmp_below, stop_mode} <= 5'h10;
    {bus_wr, bus_bit_wr, bus_rd, bus_bit_val} <= 4'h0;
    {bus_addr, bus_wdata, bus_bit_sel} <= 27'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_mode;
    t_det_reset;
    t_irq;
    t_resets;
    end_of_test;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    end_of_test;
  end
endmodule

// ===== tb/sdd_ctrl_sva.sv
`timescale 1ns/1ps
// Port-level checks on the droop detector control block
module sdd_ctrl_sva #(
  parameter bit POC_FITTED = 1'b1
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic other_reset,
  input wire logic poc_below,
  input wire logic cmp_below,
  input wire logic stop_mode,
  input wire logic bus_wr,
  input wire logic bus_bit_wr,
  input wire logic cmp_enable,
  input wire logic ref_enable,
  input wire logic droop_interrupt_request,
  input wire logic internal_reset
);
  // One domain, so one clocking and one disable
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Five samples cover two sync stages plus the output register
  a_poc_resets: assert property (poc_below [*5] |-> internal_reset)
    else $error("power-on-clear did not raise internal reset");
  a_quiet_no_rst: assert property ((!cmp_below && !poc_below) [*5] |-> !internal_reset)
    else $error("internal reset with supply above both thresholds");
  a_irq_quiet: assert property (!cmp_below [*5] |-> !droop_interrupt_request)
    else $error("interrupt request with supply above threshold");
  a_irq_needs_en: assert property (droop_interrupt_request |-> cmp_enable || $past(cmp_enable))
    else $error("interrupt request while detector disabled");
  a_ref_fitted: assert property (POC_FITTED && !$past(rst) |-> ref_enable)
    else $error("reference enable low with power-on-clear fitted");
  a_other_clr: assert property (other_reset |-> ##[1:2] !cmp_enable)
    else $error("other reset left detector enabled");
  a_poc_clr: assert property (poc_below [*6] |-> !cmp_enable)
    else $error("power-on-clear reset left detector enabled");
  a_stop_keeps: assert property ((!poc_below) [*4] ##0 (stop_mode && cmp_enable && !bus_wr
    && !bus_bit_wr && !other_reset) |=> cmp_enable)
    else $error("detector stopped in stop mode");
  a_det_keeps: assert property ((!poc_below) [*4] ##0 (internal_reset && cmp_enable
    && !other_reset) |=> cmp_enable)
    else $error("detector reset cleared its own enable");
endmodule

bind sdd_ctrl sdd_ctrl_sva #(.POC_FITTED(POC_FITTED)) u_sva (
  .mclk(mclk), .rst(rst), .other_reset(other_reset), .poc_below(poc_below),
  .cmp_below(cmp_below), .stop_mode(stop_mode), .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr),
  .cmp_enable(cmp_enable), .ref_enable(ref_enable),
  .droop_interrupt_request(droop_interrupt_request), .internal_reset(internal_reset));
